/* common/pin_own_pkg.sv */
// Purpose: shared constants for the port pin ownership controller
// Assumes: 100 MHz clk_i, classic Wishbone with 32-bit data
// Notes: registers hold their data in the low byte; upper bits read zero
package pin_own_pkg;

	localparam int NUM_PINS = 6;
	localparam int RESET_SHARED_PIN = 5;
	localparam int CLOCK_OUT_SHARED_PIN = 4;
	localparam int CLOCK_IN_SHARED_PIN = 3;

	// ***********************************************
	// timing
	// ***********************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_PULSE_NS = 50;
	localparam int RST_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 3;

	// ***********************************************
	// register map (byte addresses)
	// ***********************************************
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [7:0] A_OUT = 8'h04;
	localparam logic [7:0] A_DIR = 8'h08;
	localparam logic [7:0] A_PULL = 8'h0c;
	localparam logic [7:0] A_PINS = 8'h10;
	localparam logic [7:0] A_SLEEP = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_MASK = 8'h1c;
	localparam logic [7:0] A_PCEN = 8'h20;

	// cfg fields
	localparam int CFG_OPT_LSB = 0;
	localparam int CFG_EXTRST_BIT = 3;

	// clock option codes
	localparam logic [2:0] OPT_XTAL = 3'h0;
	localparam logic [2:0] OPT_LFXTAL = 3'h1;
	localparam logic [2:0] OPT_CERAMIC = 3'h2;
	localparam logic [2:0] OPT_EXT_RC = 3'h3;
	localparam logic [2:0] OPT_EXT_CLK = 3'h4;
	localparam logic [2:0] OPT_INT_RC = 3'h5;

	// sleep register codes
	localparam logic [1:0] SLP_RUN = 2'h0;
	localparam logic [1:0] SLP_IDLE = 2'h1;
	localparam logic [1:0] SLP_PDOWN = 2'h2;

	// status / mask bits
	localparam int ST_PCHG = 0;
	localparam int ST_EXTRST = 1;
	localparam int ST_WAKE = 2;
	localparam int ST_W = 3;

	// reset values
	localparam logic [2:0] RST_OPT = OPT_INT_RC;
	localparam logic RST_EXTRST_EN = 1'b1;

	typedef enum logic [1:0] {S_RUN, S_IDLE, S_PDOWN} sleep_t;

	// pins that belong to the port under the chosen clock and reset options
	function automatic logic [NUM_PINS-1:0] port_owned(
		input logic [2:0] opt,
		input logic ext_rst_en
	);
		logic [NUM_PINS-1:0] m;
		m = '1;
		if (ext_rst_en) begin
			m[RESET_SHARED_PIN] = 1'b0;
		end
		if (opt == OPT_XTAL || opt == OPT_LFXTAL || opt == OPT_CERAMIC) begin
			m[CLOCK_OUT_SHARED_PIN] = 1'b0;
		end
		if (opt != OPT_INT_RC) begin
			m[CLOCK_IN_SHARED_PIN] = 1'b0;
		end
		return m;
	endfunction

endpackage

/* common/pin_evt_if.sv */
// Purpose: synchronised pin levels and change strobes between modules
// Assumes: single clock domain
// Notes: changed is a one-cycle pulse per pin
`timescale 1ns/1ns
`default_nettype none
interface pin_evt_if;
	logic [pin_own_pkg::NUM_PINS-1:0] level;
	logic [pin_own_pkg::NUM_PINS-1:0] changed;
	modport src (output level, output changed);
	modport dst (input level, input changed);
endinterface
`default_nettype wire

/* verilog/pin_sync.sv */
// Purpose: two-flop synchroniser and change detector for the port pins
// Assumes: pins are asynchronous to clk_i
// Notes: edge detection looks only at the second and third stages
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [pin_own_pkg::NUM_PINS-1:0] pins_i,
	pin_evt_if.src evt
);
	typedef struct packed {
		logic [pin_own_pkg::NUM_PINS-1:0] meta;
		logic [pin_own_pkg::NUM_PINS-1:0] sync;
		logic [pin_own_pkg::NUM_PINS-1:0] prev;
		logic [pin_own_pkg::NUM_PINS-1:0] chg;
	} sync_t;

	sync_t s_q;
	sync_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = pins_i;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.chg = s_q.sync ^ s_q.prev;
	end

	// pins idle high under pull-ups, so reset to ones avoids a false change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{meta: '1, sync: '1, prev: '1, chg: '0};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign evt.level = s_q.sync;
	assign evt.changed = s_q.chg;
endmodule
`default_nettype wire

/* verilog/reset_filter.sv */
// Purpose: qualifies a low level on the shared reset pin
// Assumes: level_i is already synchronised
// Notes: active stays high for as long as the pin stays low
`timescale 1ns/1ns
`default_nettype none
module reset_filter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic level_i,
	output logic active_o
);
	typedef struct packed {
		logic [pin_own_pkg::RST_CNT_W-1:0] cnt;
		logic active;
	} filt_t;

	localparam logic [pin_own_pkg::RST_CNT_W-1:0] CNT_MAX =
		pin_own_pkg::RST_CNT_W'(pin_own_pkg::RST_CYC);

	filt_t s_q;
	filt_t s_d;

	always_comb begin
		s_d = s_q;
		if (!enable_i || level_i) begin
			s_d.cnt = '0;
			s_d.active = 1'b0;
		end else if (s_q.cnt == CNT_MAX) begin
			s_d.active = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign active_o = s_q.active;
endmodule
`default_nettype wire

/* verilog/port_pin_ownership_ctrl.sv */
// Purpose: shares six port pins between port logic, reset and clock pins
// Assumes: classic Wishbone slave, 100 MHz clk_i, sync active-high rst_i
// Notes: HAS_EEPROM selects the variant with an open-drain top pin
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module port_pin_ownership_ctrl #(
	parameter bit HAS_EEPROM = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// ***********************************************
	// wishbone slave
	// ***********************************************
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// ***********************************************
	// pins
	// ***********************************************
	input wire logic [pin_own_pkg::NUM_PINS-1:0] port_pins_i,
	output logic [pin_own_pkg::NUM_PINS-1:0] port_pins_o,
	output logic [pin_own_pkg::NUM_PINS-1:0] port_pins_oe_o,
	output logic [pin_own_pkg::NUM_PINS-1:0] pullup_en_o,
	// ***********************************************
	// system
	// ***********************************************
	output logic ext_reset_o,
	output logic cpu_halt_o,
	output logic osc_stop_o,
	output logic timer_run_o,
	output logic irq_o
);

	localparam int N = pin_own_pkg::NUM_PINS;
	localparam int TOP = pin_own_pkg::RESET_SHARED_PIN;
	localparam int W = pin_own_pkg::ST_W;

	typedef struct packed {
		logic [2:0] opt;
		logic ext_rst_en;
		logic [N-1:0] out;
		logic [N-1:0] dir;
		logic [N-2:0] pull;
		logic [N-1:0] pcen;
		logic [W-1:0] stat;
		logic [W-1:0] mask;
		pin_own_pkg::sleep_t sleep;
		logic rst_prev;
		logic ack;
		logic [7:0] rdata;
	} ctrl_t;

	ctrl_t s_q;
	ctrl_t s_d;

	pin_evt_if evt ();

	logic ext_rst_act;
	logic [N-1:0] own;
	logic [N-1:0] pc_hit;
	logic [W-1:0] ev;
	logic bus_req;
	logic wr_en;
	logic wake;
	logic [7:0] rd_mux;

	// ***********************************************
	// pin synchroniser and reset qualifier
	// ***********************************************
	pin_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pins_i(port_pins_i),
		.evt(evt.src)
	);

	reset_filter u_rstf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.enable_i(s_q.ext_rst_en),
		.level_i(evt.level[TOP]),
		.active_o(ext_rst_act)
	);

	// ***********************************************
	// read mux
	// ***********************************************
	always_comb begin
		rd_mux = 8'h00;
		unique case (adr_i)
			pin_own_pkg::A_CFG: begin
				rd_mux[pin_own_pkg::CFG_OPT_LSB +: 3] = s_q.opt;
				rd_mux[pin_own_pkg::CFG_EXTRST_BIT] = s_q.ext_rst_en;
			end
			pin_own_pkg::A_OUT: begin
				rd_mux[N-1:0] = s_q.out;
			end
			pin_own_pkg::A_DIR: begin
				rd_mux[N-1:0] = s_q.dir;
			end
			pin_own_pkg::A_PULL: begin
				rd_mux[N-2:0] = s_q.pull;
			end
			pin_own_pkg::A_PINS: begin
				// pins taken by reset or clock read as zero
				rd_mux[N-1:0] = evt.level & own;
			end
			pin_own_pkg::A_SLEEP: begin
				unique case (s_q.sleep)
					pin_own_pkg::S_RUN: begin
						rd_mux[1:0] = pin_own_pkg::SLP_RUN;
					end
					pin_own_pkg::S_IDLE: begin
						rd_mux[1:0] = pin_own_pkg::SLP_IDLE;
					end
					pin_own_pkg::S_PDOWN: begin
						rd_mux[1:0] = pin_own_pkg::SLP_PDOWN;
					end
				endcase
			end
			pin_own_pkg::A_STAT: begin
				rd_mux[W-1:0] = s_q.stat;
			end
			pin_own_pkg::A_MASK: begin
				rd_mux[W-1:0] = s_q.mask;
			end
			pin_own_pkg::A_PCEN: begin
				rd_mux[N-1:0] = s_q.pcen;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// ***********************************************
	// next state
	// ***********************************************
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.rst_prev = ext_rst_act;
		ev = '0;
		wake = 1'b0;
		own = pin_own_pkg::port_owned(s_q.opt, s_q.ext_rst_en);
		pc_hit = evt.changed & own & s_q.pcen;
		bus_req = cyc_i && stb_i && !s_q.ack;
		wr_en = bus_req && we_i && sel_i[0];

		if (|pc_hit) begin
			ev[pin_own_pkg::ST_PCHG] = 1'b1;
		end
		if (ext_rst_act && !s_q.rst_prev) begin
			ev[pin_own_pkg::ST_EXTRST] = 1'b1;
		end

		// sleep sequencing
		unique case (s_q.sleep)
			pin_own_pkg::S_RUN: begin
				if (wr_en && adr_i == pin_own_pkg::A_SLEEP) begin
					if (dat_i[1:0] == pin_own_pkg::SLP_IDLE) begin
						s_d.sleep = pin_own_pkg::S_IDLE;
					end else if (dat_i[1:0] == pin_own_pkg::SLP_PDOWN) begin
						s_d.sleep = pin_own_pkg::S_PDOWN;
					end
				end
			end
			pin_own_pkg::S_IDLE: begin
				// any unmasked interrupt source ends idle
				if (|((s_q.stat | ev) & s_q.mask) || |pc_hit) begin
					wake = 1'b1;
				end
			end
			pin_own_pkg::S_PDOWN: begin
				// only the pin change path works without the oscillator
				if (|pc_hit) begin
					wake = 1'b1;
				end
			end
		endcase
		if (wake) begin
			s_d.sleep = pin_own_pkg::S_RUN;
			ev[pin_own_pkg::ST_WAKE] = 1'b1;
		end

		// bus access
		if (bus_req) begin
			s_d.ack = 1'b1;
			s_d.rdata = rd_mux;
		end
		if (wr_en) begin
			unique case (adr_i)
				pin_own_pkg::A_CFG: begin
					s_d.opt = dat_i[pin_own_pkg::CFG_OPT_LSB +: 3];
					s_d.ext_rst_en = dat_i[pin_own_pkg::CFG_EXTRST_BIT];
				end
				pin_own_pkg::A_OUT: begin
					s_d.out = dat_i[N-1:0];
				end
				pin_own_pkg::A_DIR: begin
					s_d.dir = dat_i[N-1:0];
				end
				pin_own_pkg::A_PULL: begin
					s_d.pull = dat_i[N-2:0];
				end
				pin_own_pkg::A_MASK: begin
					s_d.mask = dat_i[W-1:0];
				end
				pin_own_pkg::A_PCEN: begin
					s_d.pcen = dat_i[N-1:0];
				end
				default: begin
					s_d.opt = s_q.opt;
				end
			endcase
		end

		// read clears status; a same-cycle event still lands
		if (bus_req && !we_i && adr_i == pin_own_pkg::A_STAT) begin
			s_d.stat = '0;
		end
		s_d.stat = s_d.stat | ev;

		// external reset returns the port to its reset state
		if (ext_rst_act) begin
			s_d.out = '0;
			s_d.dir = '0;
			s_d.pull = '0;
			s_d.sleep = pin_own_pkg::S_RUN;
		end
	end

	// ***********************************************
	// registers
	// ***********************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{
				opt: pin_own_pkg::RST_OPT,
				ext_rst_en: pin_own_pkg::RST_EXTRST_EN,
				sleep: pin_own_pkg::S_RUN,
				default: '0
			};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ***********************************************
	// pin drivers
	// ***********************************************
	// enables are gated combinationally by the reset levels so the
	// pins float at once, without waiting for any clock edge
	always_comb begin
		port_pins_o = '0;
		port_pins_oe_o = '0;
		pullup_en_o = '0;
		for (int i = 0; i < N - 1; i++) begin
			port_pins_o[i] = s_q.out[i];
			port_pins_oe_o[i] = own[i] && s_q.dir[i];
			pullup_en_o[i] = own[i] && !s_q.dir[i] && s_q.pull[i];
		end
		// top pin never drives high; input-only variant never drives
		port_pins_o[TOP] = 1'b0;
		port_pins_oe_o[TOP] = HAS_EEPROM && own[TOP] &&
			s_q.dir[TOP] && !s_q.out[TOP];
		if (rst_i || ext_rst_act) begin
			port_pins_oe_o = '0;
			pullup_en_o = '0;
		end
	end

	// ***********************************************
	// system outputs
	// ***********************************************
	assign ext_reset_o = ext_rst_act;
	assign cpu_halt_o = s_q.sleep != pin_own_pkg::S_RUN;
	assign osc_stop_o = s_q.sleep == pin_own_pkg::S_PDOWN;
	assign timer_run_o = s_q.sleep != pin_own_pkg::S_PDOWN;
	assign irq_o = |(s_q.stat & s_q.mask);
	assign ack_o = s_q.ack;
	assign dat_o = {24'h00_0000, s_q.rdata};

endmodule
`default_nettype wire

/* sim/port_pin_ownership_ctrl_assertions.sv */
// Purpose: port-level checks for the pin ownership controller
// Assumes: single clock, sync active-high reset
// Notes: bound to the top module after endmodule
`timescale 1ns/1ns
`default_nettype none
module port_pin_ownership_ctrl_assertions #(
	parameter bit HAS_EEPROM = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic [5:0] port_pins_i,
	input wire logic [5:0] port_pins_o,
	input wire logic [5:0] port_pins_oe_o,
	input wire logic [5:0] pullup_en_o,
	input wire logic ext_reset_o,
	input wire logic cpu_halt_o,
	input wire logic osc_stop_o,
	input wire logic timer_run_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ext_tri_a: assert property (ext_reset_o |->
		!port_pins_oe_o && !pullup_en_o)
		else $error("pins driven during external reset");
	top_drive_a: assert property (!port_pins_o[5] && !pullup_en_o[5])
		else $error("top pin driven high or pulled up");
	od_only_a: assert property (port_pins_oe_o[5] |-> HAS_EEPROM)
		else $error("top pin driven in input-only variant");
	pdown_a: assert property (osc_stop_o |-> cpu_halt_o && !timer_run_o)
		else $error("power-down left functions running");
	idle_a: assert property (cpu_halt_o && !osc_stop_o |-> timer_run_o)
		else $error("idle stopped the timer");
	ack_once_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered next cycle");
	ack_drop_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ext_qual_a: assert property ($rose(ext_reset_o) |->
		!$past(port_pins_i[5], 2) && !$past(port_pins_i[5], 5))
		else $error("external reset without a long low pulse");
endmodule
bind port_pin_ownership_ctrl port_pin_ownership_ctrl_assertions #(
	.HAS_EEPROM(HAS_EEPROM)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .port_pins_i(port_pins_i),
	.port_pins_o(port_pins_o), .port_pins_oe_o(port_pins_oe_o),
	.pullup_en_o(pullup_en_o), .ext_reset_o(ext_reset_o),
	.cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o),
	.timer_run_o(timer_run_o));
`default_nettype wire

/* sim/board_model.sv */
// Purpose: board side of the six shared port pins
// Assumes: device drive wins over board drive
// Notes: an undriven pin without pull-up toggles every cycle
`timescale 1ns/1ns
`default_nettype none
module board_model (
	input wire logic clk_i,
	input wire logic [5:0] dev_val_i,
	input wire logic [5:0] dev_oe_i,
	input wire logic [5:0] pull_i,
	input wire logic [5:0] brd_en_i,
	input wire logic [5:0] brd_val_i,
	output logic [5:0] pins_o
);
	logic [5:0] alt_q = 6'h15;
	always @(posedge clk_i) begin
		alt_q <= ~alt_q;
	end
	// floating lines must not settle to a convenient level
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pins_o[i] = dev_oe_i[i] ? dev_val_i[i] :
				brd_en_i[i] ? brd_val_i[i] : pull_i[i] ? 1'b1 : alt_q[i];
		end
	end
endmodule
`default_nettype wire

/* sim/port_pin_ownership_ctrl_tb.sv */
// Purpose: self-checking bench for the pin ownership controller
// Assumes: HAS_EEPROM variant, ce_i held high
// Notes: board pulls the reset line high unless a test drives it
`timescale 1ns/1ns
`default_nettype none
module port_pin_ownership_ctrl_tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ext, halt;
	logic osc, trun, irq;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000, q, rd;
	logic [5:0] ev = 6'h20, vv = 6'h20, pin, po, oe, pu, m, o;
	int err_count = 0, num_checks = 0;
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	port_pin_ownership_ctrl #(.HAS_EEPROM(1'b1)) u_dut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rd), .ack_o(ack),
		.port_pins_i(pin), .port_pins_o(po), .port_pins_oe_o(oe),
		.pullup_en_o(pu), .ext_reset_o(ext), .cpu_halt_o(halt),
		.osc_stop_o(osc), .timer_run_o(trun), .irq_o(irq));
	board_model u_brd (.clk_i(clk_i), .dev_val_i(po), .dev_oe_i(oe),
		.pull_i(pu), .brd_en_i(ev), .brd_val_i(vv), .pins_o(pin));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// reference model of pin ownership: reset pin, then the clock options
	function automatic logic [5:0] exp_own(input int opt, input int e);
		exp_own = 6'h3f;
		exp_own[5] = (e == 0);
		exp_own[4] = (opt > 2);
		exp_own[3] = (opt == 5);
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (n >= 50) begin
			// a bus that never answers ends the run as a failure
			err_count++;
			finish_test();
		end
	endtask
	task automatic tog(input int i);
		@(posedge clk_i);
		vv[i] <= ~vv[i];
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h7f2a));
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h00, 0);
		chk(q, 32'h0000_000d);
		wb(0, 8'h40, 0);
		chk(q, 32'h0000_0000);
		for (int opt = 0; opt < 6; opt++) begin
			for (int e = 0; e < 2; e++) begin
				m = exp_own(opt, e);
				o = {opt[0], 5'($urandom)};
				wb(1, 8'h00, 32'(opt + 8 * e));
				wb(1, 8'h0c, 32'h0000_001f);
				// pull-ups only act on inputs
				wb(1, 8'h08, 32'h0000_0000);
				@(negedge clk_i);
				chk(32'(pu), 32'({1'b0, m[4:0]}));
				wb(1, 8'h08, 32'h0000_003f);
				wb(1, 8'h04, 32'(o));
				@(negedge clk_i);
				chk(32'(oe), 32'({m[5] & ~o[5], m[4:0]}));
				// driven levels come back through the board and the sync
				wb(0, 8'h10, 0);
				chk(q, 32'(o & m));
			end
		end
		ev[0] <= 1;
		vv[0] <= 1;
		wb(1, 8'h08, 0);
		wb(0, 8'h18, 0);
		wb(1, 8'h20, 32'h0000_0001);
		wb(1, 8'h1c, 32'h0000_0001);
		tog(0);
		chk(32'(irq), 1);
		wb(0, 8'h18, 0);
		chk(q & 1, 1);
		@(negedge clk_i);
		chk(32'(irq), 0);
		wb(1, 8'h1c, 0);
		tog(0);
		chk(32'(irq), 0);
		wb(1, 8'h1c, 32'h0000_0001);
		wb(0, 8'h18, 0);
		chk(q & 1, 1);
		for (int s = 2; s > 0; s--) begin
			wb(1, 8'h14, 32'(s));
			@(negedge clk_i);
			chk(32'({halt, osc, trun}), (s == 2) ? 6 : 5);
			tog(0);
			chk(32'({halt, osc, trun}), 1);
			wb(0, 8'h18, 0);
			chk(q & 5, 5);
		end
		ev[5] <= 1;
		wb(1, 8'h00, 32'h0000_000d);
		wb(1, 8'h08, 32'h0000_003f);
		@(posedge clk_i);
		vv[5] <= 0;
		repeat (3) @(posedge clk_i);
		vv[5] <= 1;
		repeat (10) @(posedge clk_i);
		chk(32'(ext), 0);
		vv[5] <= 0;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		chk(32'({ext, oe}), 32'h0000_0040);
		@(posedge clk_i);
		vv[5] <= 1;
		repeat (8) @(posedge clk_i);
		chk(32'(ext), 0);
		wb(0, 8'h18, 0);
		chk(q & 2, 2);
		wb(1, 8'h08, 32'h0000_003f);
		@(negedge clk_i);
		chk(32'(oe), 32'h0000_001f);
		@(posedge clk_i);
		rst_i <= 1;
		@(negedge clk_i);
		chk(32'({oe, pu}), 0);
		@(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h08, 0);
		chk(q, 0);
		finish_test();
	end
endmodule
`default_nettype wire
